// *** mas_params.svh ***
// constants of the mode and application selector: offsets, fields, codes and timings
`ifndef MAS_PARAMS_SVH
`define MAS_PARAMS_SVH

// ==================================================
// register offsets
`define MAS_OFS_CTRL      8'h00
`define MAS_OFS_CMD       8'h04
`define MAS_OFS_APPCFG    8'h08
`define MAS_OFS_SELCFG    8'h0c
`define MAS_OFS_DAYS      8'h10
`define MAS_OFS_START     8'h14
`define MAS_OFS_END       8'h18
`define MAS_OFS_REQDLY    8'h1c
`define MAS_OFS_STATUS    8'h20
`define MAS_OFS_APPSTAT   8'h24

// ==================================================
// control fields
`define MAS_CTRL_EVT_EN   0
`define MAS_CTRL_PERM_CFG 1
`define MAS_CTRL_SCHED_EN 2

// ==================================================
// command codes
`define MAS_CMD_OFF       8'h01
`define MAS_CMD_MAN       8'h02
`define MAS_CMD_AUTO      8'h03
`define MAS_CMD_TEST_NL   8'h0c
`define MAS_CMD_RSTART    8'h0d
`define MAS_CMD_TEST_L    8'h0e
`define MAS_CMD_TEST_P    8'h0f

// ==================================================
// application codes
`define MAS_APP_SEL_INPUT 4'ha
`define MAS_APP_DRIVE     4'hb
`define MAS_APP_RESET     4'h0

// ==================================================
// event codes
`define MAS_EVT_OFF       3'h1
`define MAS_EVT_MAN       3'h2
`define MAS_EVT_AUTO      3'h3
`define MAS_EVT_TEST      3'h4
`define MAS_EVT_RSTART    3'h5

// ==================================================
// timing
`define MAS_CLK_PERIOD_NS 20
`define MAS_MS_TIME_NS    1000000
`define MAS_MS_CYCLES     (`MAS_MS_TIME_NS / `MAS_CLK_PERIOD_NS)
`define MAS_STABLE_MS     1000
`define MAS_MISSING_MS    5000

`endif

// *** mas_pkg.sv ***
// types of the mode and application selector
package mas_pkg;
	// one-hot operating mode
	typedef enum logic [4:0] {
		MAS_OFF    = 5'b00001,
		MAS_MAN    = 5'b00010,
		MAS_AUTO   = 5'b00100,
		MAS_TEST   = 5'b01000,
		MAS_RSTART = 5'b10000
	} mas_mode_t;

	// mode indicator group
	typedef struct packed {
		logic mode_off;
		logic mode_manual;
		logic mode_auto;
		logic mode_test;
		logic mode_remote_start;
		logic not_off;
		logic any_automatic;
	} mas_ind_t;

	// application status group
	typedef struct packed {
		logic [10:0] app;
		logic        emergency_plant;
		logic        grid_parallel_plant;
		logic        gen_parallel_plant;
		logic        engine_only;
	} mas_app_t;

	// mode change event
	typedef struct packed {
		logic       valid;
		logic [2:0] code;
	} mas_evt_t;
endpackage

// *** mas_top.sv ***
// mode and application selector: remote start arbitration, mode indicators, application choice
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "mas_params.svh"

module mas_top #(
	parameter int MS_CYCLES  = `MAS_MS_CYCLES,
	parameter int STABLE_MS  = `MAS_STABLE_MS,
	parameter int MISSING_MS = `MAS_MISSING_MS
) (
	input  wire logic              core_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic [7:0]        addr_in,
	input  wire logic [31:0]       wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [31:0]       rdata_out,
	input  wire logic              remote_start_permit_input_in,
	input  wire logic              remote_start_request_input_in,
	input  wire logic              test_request_input_in,
	input  wire logic              load_inhibit_in,
	input  wire logic              submode_block_in,
	input  wire logic              engine_stopped_in,
	input  wire logic [10:0]       app_select_input_in,
	input  wire logic              rtc_valid_in,
	input  wire logic [2:0]        rtc_weekday_in,
	input  wire logic [10:0]       rtc_minute_in,
	output mas_pkg::mas_ind_t      ind_out,
	output mas_pkg::mas_app_t      app_out,
	output mas_pkg::mas_evt_t      event_out,
	output logic                   engine_run_out,
	output logic                   gen_load_out,
	output logic                   ac_measure_en_out,
	output logic                   clock_invalid_anomaly_out,
	output logic                   incoherent_config_anomaly_out,
	output logic                   incoherent_is_alarm_out
);
	import mas_pkg::*;

	// ==================================================
	// helpers
	// lowest set bit as one-hot, zero when none
	function automatic logic [10:0] first_set(input logic [10:0] v);
		logic [10:0] r;
		r = 11'h000;
		for (int i = 10; i >= 0; i--) begin
			if (v[i]) begin
				r = 11'h000;
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction

	// application code to one-hot flag, zero for codes without an application
	function automatic logic [10:0] code_onehot(input logic [3:0] c);
		logic [10:0] r;
		r = 11'h000;
		if (c < `MAS_APP_SEL_INPUT)
			r[c] = 1'b1;
		else if (c == `MAS_APP_DRIVE)
			r[10] = 1'b1;
		return r;
	endfunction

	// ==================================================
	// pin synchronisers
	logic [15:0] sync1;
	logic [15:0] sync2;
	logic [15:0] pins_raw;
	assign pins_raw = {remote_start_permit_input_in, remote_start_request_input_in, test_request_input_in,
		load_inhibit_in, submode_block_in, app_select_input_in};

	// two stages before any logic looks at the pins
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1 <= 16'h0000;
			sync2 <= 16'h0000;
		end else begin
			sync1 <= pins_raw;
			sync2 <= sync1;
		end
	end

	logic        permit_s;
	logic        request_s;
	logic        test_s;
	logic        inhibit_s;
	logic        block_s;
	logic [10:0] sel_s;
	logic        stopped_s;
	assign {permit_s, request_s, test_s, inhibit_s, block_s, sel_s} = sync2;

	// engine stopped also comes from a pin
	logic stop1;
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stop1     <= 1'b0;
			stopped_s <= 1'b0;
		end else begin
			stop1     <= engine_stopped_in;
			stopped_s <= stop1;
		end
	end

	// ==================================================
	// registers
	logic [2:0]  ctrl;
	logic [3:0]  app_cfg;
	logic [10:0] sel_cfg;
	logic [6:0]  sched_days;
	logic [10:0] sched_start;
	logic [10:0] sched_end;
	logic [15:0] req_delay_ms;
	logic        wr_cmd;
	assign wr_cmd = wr_in && (addr_in == `MAS_OFS_CMD);

	// configuration writes
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl         <= 3'h0;
			app_cfg      <= `MAS_APP_RESET;
			sel_cfg      <= 11'h000;
			sched_days   <= 7'h00;
			sched_start  <= 11'h000;
			sched_end    <= 11'h000;
			req_delay_ms <= 16'h0000;
		end else if (wr_in) begin
			case (addr_in)
				`MAS_OFS_CTRL:   ctrl         <= wdata_in[2:0];
				`MAS_OFS_APPCFG: app_cfg      <= wdata_in[3:0];
				`MAS_OFS_SELCFG: sel_cfg      <= wdata_in[10:0];
				`MAS_OFS_DAYS:   sched_days   <= wdata_in[6:0];
				`MAS_OFS_START:  sched_start  <= wdata_in[10:0];
				`MAS_OFS_END:    sched_end    <= wdata_in[10:0];
				`MAS_OFS_REQDLY: req_delay_ms <= wdata_in[15:0];
				default: ;
			endcase
		end
	end

	// ==================================================
	// millisecond tick shared by all delays
	logic [31:0] ms_cnt;
	logic        ms_tick;
	assign ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			ms_cnt <= 32'h0;
		else if (ms_tick)
			ms_cnt <= 32'h0;
		else
			ms_cnt <= ms_cnt + 32'h1;
	end

	// ==================================================
	// remote start sources
	mas_mode_t mode;
	mas_mode_t next_mode;
	logic      permitted;
	logic      req_delayed;
	logic [15:0] req_ms;
	logic      in_window;
	logic      sched_req;
	logic      cmd_rs;
	logic      cmd_test;
	logic      rs_want;
	logic      test_want;

	// unassigned permit input means always permitted
	assign permitted = !ctrl[`MAS_CTRL_PERM_CFG] || permit_s;

	// activation delay counted in ms, dropped at once on release
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			req_ms      <= 16'h0000;
			req_delayed <= 1'b0;
		end else if (!request_s) begin
			req_ms      <= 16'h0000;
			req_delayed <= 1'b0;
		end else if (req_ms >= req_delay_ms) begin
			req_delayed <= 1'b1;
		end else if (ms_tick) begin
			req_ms <= req_ms + 16'h0001;
		end
	end

	// window wraps past midnight when end precedes start
	always_comb begin
		if (sched_start == sched_end)
			in_window = 1'b1;
		else if (sched_start < sched_end)
			in_window = (rtc_minute_in >= sched_start) && (rtc_minute_in < sched_end);
		else
			in_window = (rtc_minute_in >= sched_start) || (rtc_minute_in < sched_end);
	end

	// untrusted clock never starts the engine, it raises the anomaly instead
	assign sched_req = ctrl[`MAS_CTRL_SCHED_EN] && rtc_valid_in && in_window
		&& sched_days[rtc_weekday_in];
	assign clock_invalid_anomaly_out = ctrl[`MAS_CTRL_SCHED_EN] && (sched_days != 7'h00)
		&& !rtc_valid_in;

	// command latches; a new main mode command cancels them
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_rs   <= 1'b0;
			cmd_test <= 1'b0;
		end else if (wr_cmd) begin
			case (wdata_in[7:0])
				`MAS_CMD_RSTART: cmd_rs <= 1'b1;
				`MAS_CMD_TEST_NL, `MAS_CMD_TEST_L, `MAS_CMD_TEST_P: cmd_test <= 1'b1;
				`MAS_CMD_OFF, `MAS_CMD_MAN, `MAS_CMD_AUTO: begin
					cmd_rs   <= 1'b0;
					cmd_test <= 1'b0;
				end
				default: ;
			endcase
		end else if (mode == MAS_RSTART) begin
			cmd_test <= 1'b0;
		end
	end

	assign rs_want   = permitted && (req_delayed || sched_req || cmd_rs);
	assign test_want = test_s || cmd_test;

	// ==================================================
	// operating mode
	mas_mode_t main_mode;

	// main mode from host commands, off after reset
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			main_mode <= MAS_OFF;
		else if (wr_cmd) begin
			case (wdata_in[7:0])
				`MAS_CMD_OFF:  main_mode <= MAS_OFF;
				`MAS_CMD_MAN:  main_mode <= MAS_MAN;
				`MAS_CMD_AUTO: main_mode <= MAS_AUTO;
				default: ;
			endcase
		end
	end

	// sub-modes can be held once running but not entered while blocked
	always_comb begin
		case (main_mode)
			MAS_AUTO: begin
				if (rs_want && (mode == MAS_RSTART || !block_s))
					next_mode = MAS_RSTART;
				else if (test_want && (mode == MAS_TEST || !block_s))
					next_mode = MAS_TEST;
				else
					next_mode = MAS_AUTO;
			end
			MAS_MAN: next_mode = MAS_MAN;
			default: next_mode = MAS_OFF;
		endcase
	end

	// single one-hot state register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			mode <= MAS_OFF;
		else
			mode <= next_mode;
	end

	// indicators straight off the state flops
	assign ind_out.mode_off          = mode[0];
	assign ind_out.mode_manual       = mode[1];
	assign ind_out.mode_auto         = mode[2];
	assign ind_out.mode_test         = mode[3];
	assign ind_out.mode_remote_start = mode[4];
	assign ind_out.not_off           = !mode[0];
	assign ind_out.any_automatic     = mode[2] || mode[3] || mode[4];

	// engine and load demand of the sub-modes
	assign engine_run_out = mode[3] || mode[4];
	assign gen_load_out   = mode[4] && !inhibit_s;

	// ==================================================
	// mode change events
	function automatic logic [2:0] evt_code(input mas_mode_t m);
		case (m)
			MAS_MAN:    return `MAS_EVT_MAN;
			MAS_AUTO:   return `MAS_EVT_AUTO;
			MAS_TEST:   return `MAS_EVT_TEST;
			MAS_RSTART: return `MAS_EVT_RSTART;
			default:    return `MAS_EVT_OFF;
		endcase
	endfunction

	// one pulse per change, naming the new mode
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			event_out <= '0;
		end else begin
			event_out.valid <= ctrl[`MAS_CTRL_EVT_EN] && (next_mode != mode);
			event_out.code  <= evt_code(next_mode);
		end
	end

	// ==================================================
	// application selection
	logic [10:0] sel_act;
	logic [10:0] sel_prev;
	logic [15:0] stable_ms;
	logic [15:0] missing_ms;
	logic [10:0] sel_app;
	logic        sel_valid;
	logic        sel_mode;
	logic [10:0] app_cur;

	assign sel_mode = (app_cfg == `MAS_APP_SEL_INPUT);
	assign sel_act  = sel_s & sel_cfg;

	// stability and absence timers in ms
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sel_prev   <= 11'h000;
			stable_ms  <= 16'h0000;
			missing_ms <= 16'h0000;
		end else begin
			sel_prev <= sel_act;
			if (sel_act != sel_prev)
				stable_ms <= 16'h0000;
			else if (ms_tick && stable_ms < 16'(STABLE_MS))
				stable_ms <= stable_ms + 16'h0001;
			if (!sel_mode || sel_act != 11'h000)
				missing_ms <= 16'h0000;
			else if (ms_tick && missing_ms < 16'(MISSING_MS))
				missing_ms <= missing_ms + 16'h0001;
		end
	end

	// take a new choice only when stopped, off and settled
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sel_app   <= 11'h000;
			sel_valid <= 1'b0;
		end else if (sel_mode && sel_act != 11'h000 && sel_act == sel_prev
			&& stable_ms >= 16'(STABLE_MS) && stopped_s && mode == MAS_OFF) begin
			sel_app   <= first_set(sel_act);
			sel_valid <= 1'b1;
		end
	end

	// previous selection kept while inputs are missing
	assign app_cur = sel_mode ? (sel_valid ? sel_app : 11'h000) : code_onehot(app_cfg);

	assign incoherent_config_anomaly_out = sel_mode && (missing_ms >= 16'(MISSING_MS));
	assign incoherent_is_alarm_out = incoherent_config_anomaly_out
		&& !(sel_valid && sel_cfg != 11'h000);

	// plant class flags and per application flags, registered
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			app_out <= '0;
		end else begin
			app_out.app                 <= app_cur;
			app_out.emergency_plant     <= |(app_cur & 11'h2d6);
			app_out.grid_parallel_plant <= |(app_cur & 11'h39c);
			app_out.gen_parallel_plant  <= |(app_cur & 11'h3e0);
			app_out.engine_only         <= app_cur[10];
		end
	end

	// engine only plant runs no ac measurement
	assign ac_measure_en_out = !app_out.engine_only;

	// ==================================================
	// read port, data one cycle after the strobe
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 32'h0;
		end else if (rd_in) begin
			case (addr_in)
				`MAS_OFS_CTRL:    rdata_out <= {29'h0, ctrl};
				`MAS_OFS_APPCFG:  rdata_out <= {28'h0, app_cfg};
				`MAS_OFS_SELCFG:  rdata_out <= {21'h0, sel_cfg};
				`MAS_OFS_DAYS:    rdata_out <= {25'h0, sched_days};
				`MAS_OFS_START:   rdata_out <= {21'h0, sched_start};
				`MAS_OFS_END:     rdata_out <= {21'h0, sched_end};
				`MAS_OFS_REQDLY:  rdata_out <= {16'h0, req_delay_ms};
				`MAS_OFS_STATUS:  rdata_out <= {22'h0, incoherent_is_alarm_out, incoherent_config_anomaly_out,
					clock_invalid_anomaly_out, cmd_test, cmd_rs, 5'(mode)};
				`MAS_OFS_APPSTAT: rdata_out <= {20'h0, sel_valid, app_out.app};
				default:          rdata_out <= 32'h0;
			endcase
		end else begin
			rdata_out <= 32'h0;
		end
	end
endmodule

// *** mas_assertions.sv ***
// concurrent checks on the ports of the mode and application selector
`timescale 1ns/100ps
`include "mas_params.svh"

module mas_checker (
	input  wire logic              core_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              load_inhibit_in,
	input  wire logic              submode_block_in,
	input  wire mas_pkg::mas_ind_t ind_out,
	input  wire mas_pkg::mas_app_t app_out,
	input  wire mas_pkg::mas_evt_t event_out,
	input  wire logic              engine_run_out,
	input  wire logic              gen_load_out,
	input  wire logic              ac_measure_en_out
);
	import mas_pkg::*;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	// ==================================================
	// mode indicators
	a_one_mode_hot: assert property (
		$onehot({ind_out.mode_off, ind_out.mode_manual, ind_out.mode_auto, ind_out.mode_test,
			ind_out.mode_remote_start})) else $error("mode indicators not one hot");
	a_not_off_ind: assert property (
		ind_out.not_off == !ind_out.mode_off) else $error("not off indicator wrong");
	a_any_auto_ind: assert property (
		ind_out.any_automatic == (ind_out.mode_auto | ind_out.mode_test | ind_out.mode_remote_start))
		else $error("automatic group indicator wrong");
	// load and engine follow the sub-mode; inhibit seen through two sync stages
	a_load_needs_rs: assert property (
		gen_load_out |-> ind_out.mode_remote_start) else $error("load outside remote start");
	a_inhibit_unload: assert property (
		load_inhibit_in [*4] |-> !gen_load_out) else $error("load despite inhibit");
	a_engine_run: assert property (
		engine_run_out == (ind_out.mode_test | ind_out.mode_remote_start)) else $error("engine run wrong");
	a_block_entry: assert property (
		submode_block_in [*4] |-> !$rose(ind_out.mode_remote_start) && !$rose(ind_out.mode_test))
		else $error("sub-mode entered while blocked");
	// ==================================================
	// events
	a_event_change: assert property (
		event_out.valid |-> ind_out != $past(ind_out)) else $error("event without mode change");
	a_event_code: assert property (
		event_out.valid |-> (event_out.code == `MAS_EVT_RSTART) == ind_out.mode_remote_start)
		else $error("event code wrong");
	// ==================================================
	// application flags
	a_app_single: assert property (
		$onehot0(app_out.app) && app_out.engine_only == app_out.app[10]) else $error("application flags wrong");
	a_plant_flags: assert property (
		app_out.gen_parallel_plant == (|app_out.app[9:5]) && app_out.grid_parallel_plant ==
			(|{app_out.app[9:7], app_out.app[4:2]})) else $error("plant class flags wrong");
	a_ac_measure: assert property (
		ac_measure_en_out == !app_out.engine_only) else $error("ac measure enable wrong");

	c_remote_start: cover property ($rose(ind_out.mode_remote_start));
	c_event: cover property (event_out.valid);
	c_engine_only: cover property ($rose(app_out.engine_only));
endmodule

bind mas_top mas_checker chk_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.load_inhibit_in(load_inhibit_in), .submode_block_in(submode_block_in), .ind_out(ind_out),
	.app_out(app_out), .event_out(event_out), .engine_run_out(engine_run_out),
	.gen_load_out(gen_load_out), .ac_measure_en_out(ac_measure_en_out));

// *** mas_operator_model.sv ***
// operator side: permit key, request pins, inhibit and the application selector switch
`timescale 1ns/100ps

module mas_operator_model (
	input  wire logic        clk_in,
	output logic             permit_out,
	output logic             request_out,
	output logic             test_out,
	output logic             inhibit_out,
	output logic             block_out,
	output logic             stopped_out,
	output logic [10:0]      sel_out
);
	// contact state held between calls; contacts open, engine at standstill
	logic [5:0]  levels  = 6'h01;
	logic [10:0] contact = 11'h000;

	// pins always show the held contact state
	assign {permit_out, request_out, test_out, inhibit_out, block_out, stopped_out} = levels;
	assign sel_out = contact;

	// levels move just after an edge, bounce-free
	task automatic set_levels(input logic [5:0] lv);
		@(posedge clk_in);
		levels <= lv;
	endtask

	// rotary switch breaks the old contact before making the new one
	task automatic turn_sel(input logic [10:0] v);
		@(posedge clk_in);
		contact <= 11'h000;
		@(posedge clk_in);
		contact <= v;
	endtask
endmodule

// *** testbench.sv ***
// self-checking bench of the mode and application selector
`timescale 1ns/100ps
`include "mas_params.svh"

module testbench;
	import mas_pkg::*;
	localparam logic [5:0] P_PERMIT = 6'h20, P_REQ = 6'h10, P_TEST = 6'h08, P_INH = 6'h04, P_BLK = 6'h02;
	localparam logic [5:0] P_STOP = 6'h01;
	logic        clk, rst_n, wr, rd, rtc_valid;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic        permit, req, tst, inh, blk, stopped;
	logic [10:0] sel, minute;
	logic [2:0]  wday;
	logic [2:0]  ev_last = 3'h0;
	mas_ind_t    ind;
	mas_app_t    app;
	mas_evt_t    evt;
	logic        run, load, ac_en, clk_bad, incoh, alarm;
	int          ev_cnt = 0;
	int          fail_count, checks;

	mas_top #(.MS_CYCLES(4), .STABLE_MS(3), .MISSING_MS(5)) dut_u (
		.core_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .remote_start_permit_input_in(permit), .remote_start_request_input_in(req),
		.test_request_input_in(tst), .load_inhibit_in(inh), .submode_block_in(blk),
		.engine_stopped_in(stopped), .app_select_input_in(sel), .rtc_valid_in(rtc_valid),
		.rtc_weekday_in(wday), .rtc_minute_in(minute), .ind_out(ind), .app_out(app), .event_out(evt),
		.engine_run_out(run), .gen_load_out(load), .ac_measure_en_out(ac_en),
		.clock_invalid_anomaly_out(clk_bad), .incoherent_config_anomaly_out(incoh),
		.incoherent_is_alarm_out(alarm));
	mas_operator_model op_u (.clk_in(clk), .permit_out(permit), .request_out(req), .test_out(tst),
		.inhibit_out(inh), .block_out(blk), .stopped_out(stopped), .sel_out(sel));

	// ==================================================
	// clock, event log, watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (evt.valid === 1'b1) begin
			ev_last <= evt.code;
			ev_cnt <= ev_cnt + 1;
		end
	end
	// generous: the sequence needs well under two thousand cycles
	initial begin
		repeat (6000) @(posedge clk);
		fail_count++;
		end_of_test();
	end

	// ==================================================
	// helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] c);
		bus_wr(`MAS_OFS_CMD, {24'h0, c});
	endtask
	// real-time clock inputs move together just after an edge
	task automatic set_rtc(input logic v, input logic [2:0] d, input logic [10:0] m);
		@(posedge clk);
		{rtc_valid, wday, minute} <= {v, d, m};
	endtask
	task automatic mode_is(input mas_mode_t m);
		logic [31:0] v;
		idle(5);
		chk("mode ind", {27'h0, m[0], m[1], m[2], m[3], m[4]}, {27'h0, ind.mode_off, ind.mode_manual,
			ind.mode_auto, ind.mode_test, ind.mode_remote_start});
		bus_rd(`MAS_OFS_STATUS, v);
		chk("status mode", {27'h0, m}, {27'h0, v[4:0]});
	endtask
	// expected flags built from the code table and plant class masks
	task automatic app_is(input int c);
		mas_app_t e;
		e = '0;
		if (c <= 9) e.app[c] = 1'b1;
		if (c == 11) e.app[10] = 1'b1;
		e.emergency_plant = c inside {1, 2, 4, 6, 7, 9};
		e.grid_parallel_plant = c inside {2, 3, 4, 7, 8, 9};
		e.gen_parallel_plant = c inside {[5:9]};
		e.engine_only = (c == 11);
		chk("app flags", {17'h0, e}, {17'h0, app});
		chk("ac measure", {31'h0, c != 11}, {31'h0, ac_en});
	endtask
	task automatic end_of_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ==================================================
	// sequence
	initial begin
		logic [31:0] v;
		int n0;
		rst_n = 1'b0;
		{wr, rd, addr, wdata} = '0;
		{rtc_valid, wday, minute} = {1'b1, 3'h2, 11'h500};
		{fail_count, checks} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		mode_is(MAS_OFF);
		chk("not off", 32'h0, {31'h0, ind.not_off});
		bus_wr(8'hfc, 32'hffffffff);
		bus_rd(8'hfc, v);
		chk("unmapped", 32'h0, v);
		app_is(0);
		// main modes and remote start from the host
		bus_wr(`MAS_OFS_CTRL, 32'h1);
		cmd(`MAS_CMD_AUTO);
		mode_is(MAS_AUTO);
		chk("auto group", 32'h3, {30'h0, ind.not_off, ind.any_automatic});
		chk("auto event", {29'h0, `MAS_EVT_AUTO}, {29'h0, ev_last});
		cmd(`MAS_CMD_RSTART);
		mode_is(MAS_RSTART);
		chk("rs load run", 32'h3, {30'h0, load, run});
		chk("rs event", {29'h0, `MAS_EVT_RSTART}, {29'h0, ev_last});
		op_u.set_levels(P_STOP | P_INH);
		mode_is(MAS_RSTART);
		chk("inhibited", 32'h1, {30'h0, load, run});
		op_u.set_levels(P_STOP);
		cmd(`MAS_CMD_TEST_NL);
		mode_is(MAS_RSTART);
		cmd(`MAS_CMD_AUTO);
		cmd(`MAS_CMD_TEST_P);
		mode_is(MAS_TEST);
		cmd(`MAS_CMD_AUTO);
		op_u.set_levels(P_STOP | P_TEST);
		mode_is(MAS_TEST);
		chk("test event", {29'h0, `MAS_EVT_TEST}, {29'h0, ev_last});
		chk("test group", 32'h3, {30'h0, ind.not_off, ind.any_automatic});
		cmd(`MAS_CMD_RSTART);
		mode_is(MAS_RSTART);
		op_u.set_levels(P_STOP);
		cmd(`MAS_CMD_AUTO);
		// sub-modes refused while blocked
		op_u.set_levels(P_STOP | P_BLK);
		cmd(`MAS_CMD_RSTART);
		mode_is(MAS_AUTO);
		cmd(`MAS_CMD_TEST_L);
		mode_is(MAS_AUTO);
		cmd(`MAS_CMD_AUTO);
		op_u.set_levels(P_STOP);
		// permit input assigned
		bus_wr(`MAS_OFS_CTRL, 32'h3);
		cmd(`MAS_CMD_RSTART);
		mode_is(MAS_AUTO);
		cmd(`MAS_CMD_AUTO);
		op_u.set_levels(P_STOP | P_PERMIT);
		cmd(`MAS_CMD_RSTART);
		mode_is(MAS_RSTART);
		cmd(`MAS_CMD_AUTO);
		// request pin with a two tick delay
		bus_wr(`MAS_OFS_REQDLY, 32'h2);
		op_u.set_levels(P_STOP | P_PERMIT | P_REQ);
		mode_is(MAS_AUTO);
		idle(16);
		mode_is(MAS_RSTART);
		op_u.set_levels(P_STOP | P_PERMIT);
		mode_is(MAS_AUTO);
		// weekly scheduler
		bus_wr(`MAS_OFS_CTRL, 32'h5);
		bus_wr(`MAS_OFS_DAYS, 32'h4);
		bus_wr(`MAS_OFS_START, 32'h64);
		bus_wr(`MAS_OFS_END, 32'h64);
		mode_is(MAS_RSTART);
		set_rtc(1'b0, 3'h2, 11'h500);
		idle(2);
		chk("clock invalid", 32'h1, {31'h0, clk_bad});
		set_rtc(1'b1, 3'h2, 11'h500);
		bus_wr(`MAS_OFS_START, 32'ha);
		bus_wr(`MAS_OFS_END, 32'h14);
		set_rtc(1'b1, 3'h2, 11'h01e);
		mode_is(MAS_AUTO);
		chk("clock valid", 32'h0, {31'h0, clk_bad});
		set_rtc(1'b1, 3'h2, 11'h00f);
		mode_is(MAS_RSTART);
		set_rtc(1'b1, 3'h3, 11'h00f);
		mode_is(MAS_AUTO);
		// window wrapping past midnight
		bus_wr(`MAS_OFS_START, 32'h14);
		bus_wr(`MAS_OFS_END, 32'ha);
		set_rtc(1'b1, 3'h2, 11'h00f);
		mode_is(MAS_AUTO);
		set_rtc(1'b1, 3'h2, 11'h500);
		mode_is(MAS_RSTART);
		// event logging follows its enable
		bus_wr(`MAS_OFS_CTRL, 32'h0);
		n0 = ev_cnt;
		cmd(`MAS_CMD_OFF);
		mode_is(MAS_OFF);
		chk("silent", 32'(n0), 32'(ev_cnt));
		bus_wr(`MAS_OFS_CTRL, 32'h1);
		cmd(`MAS_CMD_MAN);
		mode_is(MAS_MAN);
		chk("one event", 32'(n0 + 1), 32'(ev_cnt));
		chk("man event", {29'h0, `MAS_EVT_MAN}, {29'h0, ev_last});
		cmd(`MAS_CMD_OFF);
		mode_is(MAS_OFF);
		chk("off event", {29'h0, `MAS_EVT_OFF}, {29'h0, ev_last});
		// every direct code, unused ones included
		for (int c = 0; c < 16; c++) begin
			if (c != 10) begin
				bus_wr(`MAS_OFS_APPCFG, 32'(c));
				idle(2);
				app_is(c);
			end
		end
		// selector inputs
		bus_wr(`MAS_OFS_SELCFG, 32'h7ff);
		op_u.turn_sel(11'h028);
		bus_wr(`MAS_OFS_APPCFG, 32'ha);
		idle(30);
		app_is(3);
		op_u.set_levels(6'h00);
		op_u.turn_sel(11'h004);
		idle(30);
		app_is(3);
		cmd(`MAS_CMD_MAN);
		op_u.set_levels(P_STOP);
		idle(30);
		app_is(3);
		cmd(`MAS_CMD_OFF);
		idle(30);
		app_is(2);
		op_u.turn_sel(11'h000);
		idle(10);
		chk("anomaly early", 32'h0, {31'h0, incoh});
		idle(20);
		chk("warning", 32'h2, {30'h0, incoh, alarm});
		app_is(2);
		// power-on with nothing selected
		@(posedge clk) rst_n <= 1'b0;
		idle(2);
		@(posedge clk) rst_n <= 1'b1;
		bus_wr(`MAS_OFS_SELCFG, 32'h7ff);
		bus_wr(`MAS_OFS_APPCFG, 32'ha);
		idle(30);
		chk("alarm", 32'h3, {30'h0, incoh, alarm});
		op_u.turn_sel(11'h400);
		idle(30);
		app_is(11);
		chk("anomaly gone", 32'h0, {31'h0, incoh});
		end_of_test();
	end
endmodule
